/* swd_regs.vh */
// Purpose: Register map, field positions and timing constants of the watchdog.
// Assumes: 32-bit AXI4-Lite slave, one aligned word per register.
// Notes: Definitions only.
//
// How it works
// R1: After every reset the watchdog is enabled and counting with no software action.
// R2: A disable command stops it and an enable command restarts it, accepted at any time.
// R3: Software must service the watchdog before the counter overflows.
// R4: On overflow a prewarning interrupt is raised first and a reset request follows.
// R5: The counter is 16 bits and ticks on the clock divided by 16384 or 256.
// R6: A service loads the reload value into the counter and clears the prescaler.
// R7: The programmable reload value sets the counter's start and so the interval.
// R8: Prescaler and reload together span a very short to a very long interval.
// R9: The reset defaults of prescaler and reload give the documented power-up interval.
// R10: The counter counts up from the reload value and overflows on wrap to zero.
`ifndef SWD_REGS_VH
`define SWD_REGS_VH

// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define SWD_CTRL_OFS 8'h00
`define SWD_RELOAD_OFS 8'h04
`define SWD_SERVICE_OFS 8'h08
`define SWD_COUNT_OFS 8'h0c
`define SWD_STATUS_OFS 8'h10
`define SWD_IRQ_MASK_OFS 8'h14
`define SWD_SVC_KEY 32'h0000a5a5

// ---------------------------------------------
// Fields
// ---------------------------------------------
`define SWD_CTRL_EN_BIT 0
`define SWD_CTRL_DIS_BIT 1
`define SWD_CTRL_FAST_BIT 2
`define SWD_ST_PREWARN_BIT 0
`define SWD_ST_RESET_BIT 1
`define SWD_ST_RUN_BIT 2

// ---------------------------------------------
// Reset values and timing
// ---------------------------------------------
// Four slow ticks from reset: a 65536-cycle interval, about 6.5 ms at 10 MHz
`define SWD_RELOAD_RST 16'hfffc
`define SWD_FAST_RST 1'b0
`define SWD_DIV_SLOW 16384
`define SWD_DIV_FAST 256
`define SWD_PREWARN_TICKS 16'h0001
`define SWD_RST_HOLD 5'h10

`endif

/* swd_prescaler.v */
// Purpose: Selectable clock prescaler producing one-cycle ticks.
// Assumes: Divisors are powers of two.
// Notes: Clear restarts the division from zero.
`timescale 1ns/1ps
`default_nettype none
module swd_prescaler #(
   parameter DIV_SLOW = 16384,
   parameter DIV_FAST = 256
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Control
   input wire clear,
   input wire fastSel,
   // Tick
   output reg tick_q
);
   // Terminal counts worked out at full width, then cut to the counter
   localparam [31:0] LAST_SLOW = DIV_SLOW - 1;
   localparam [31:0] LAST_FAST = DIV_FAST - 1;
   reg [13:0] cnt_q;
   wire [13:0] lastVal = fastSel ? LAST_FAST[13:0] : LAST_SLOW[13:0];
   wire hit = (cnt_q >= lastVal);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 14'h0000;
         tick_q <= 1'b0;
      end else if (clear) begin
         cnt_q <= 14'h0000; // R6
         tick_q <= 1'b0;
      end else begin
         cnt_q <= hit ? 14'h0000 : cnt_q + 14'h0001; // R5
         tick_q <= hit;
      end
   end
endmodule
`default_nettype wire

/* swd_watchdog.v */
// Purpose: Supervisory 16-bit watchdog with AXI4-Lite registers.
// Assumes: Single clock; inputs synchronous to clk.
// Notes: Prewarning precedes the reset request by a fixed tick count.
`include "swd_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module swd_watchdog #(
   parameter PREWARN_TICKS = 2
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // AXI4-Lite write
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // System
   output reg irq_q,
   output reg resetReq_q
);
   // ---------------------------------------------
   // Write channel capture
   // ---------------------------------------------
   reg awHave_q;
   reg wHave_q;
   reg [7:0] awAddr_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;
   wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= !awHave_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHave_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_q[7:2] <= `SWD_IRQ_MASK_OFS >> 2) &&
               (awAddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire wrCtrl = doWrite && awAddr_q == `SWD_CTRL_OFS && wStrb_q[0];
   wire wrReload = doWrite && awAddr_q == `SWD_RELOAD_OFS;
   wire wrService = doWrite && awAddr_q == `SWD_SERVICE_OFS && wData_q == `SWD_SVC_KEY;
   wire wrStatus = doWrite && awAddr_q == `SWD_STATUS_OFS && wStrb_q[0];
   wire wrMask = doWrite && awAddr_q == `SWD_IRQ_MASK_OFS && wStrb_q[0];

   // ---------------------------------------------
   // Watchdog core
   // ---------------------------------------------
   reg run_q;
   reg fast_q;
   reg [15:0] reload_q;
   reg [15:0] count_q;
   reg [1:0] stat_q;
   reg [1:0] mask_q;
   reg [1:0] phase_q;
   reg [7:0] warnCnt_q;
   reg [4:0] rstHold_q;
   wire tick;
   wire svc = wrService || (wrCtrl && wData_q[`SWD_CTRL_EN_BIT]);

   localparam [31:0] PW_LAST = PREWARN_TICKS - 1;
   localparam PH_RUN = 2'b01;
   localparam PH_WARN = 2'b10;

   swd_prescaler #(
      .DIV_SLOW(`SWD_DIV_SLOW),
      .DIV_FAST(`SWD_DIV_FAST)
   ) uPre (
      .clk(clk),
      .rst(rst),
      .clear(svc || !run_q), // R6
      .fastSel(fast_q), // R8
      .tick_q(tick)
   );

   wire wrap = tick && count_q == 16'hffff; // R10
   wire warnDone = tick && warnCnt_q == PW_LAST[7:0];
   wire evPre = run_q && phase_q == PH_RUN && wrap;
   wire evRst = run_q && phase_q == PH_WARN && warnDone;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         run_q <= 1'b1; // R1
         fast_q <= `SWD_FAST_RST; // R9
         reload_q <= `SWD_RELOAD_RST; // R9
         count_q <= `SWD_RELOAD_RST;
         phase_q <= PH_RUN;
         warnCnt_q <= 8'h00;
         stat_q <= 2'b00;
         mask_q <= 2'b00;
         rstHold_q <= 5'h00;
         irq_q <= 1'b0;
         resetReq_q <= 1'b0;
      end else begin
         if (wrCtrl) begin
            if (wData_q[`SWD_CTRL_DIS_BIT])
               run_q <= 1'b0; // R2
            else if (wData_q[`SWD_CTRL_EN_BIT])
               run_q <= 1'b1; // R2
            fast_q <= wData_q[`SWD_CTRL_FAST_BIT]; // R5
         end
         if (wrReload) begin
            if (wStrb_q[0]) reload_q[7:0] <= wData_q[7:0]; // R7
            if (wStrb_q[1]) reload_q[15:8] <= wData_q[15:8];
         end
         if (wrMask)
            mask_q <= wData_q[1:0];
         if (svc) begin
            count_q <= reload_q; // R6
            phase_q <= PH_RUN;
            warnCnt_q <= 8'h00;
         end else if (run_q && tick) begin
            case (phase_q)
               PH_RUN: begin
                  count_q <= count_q + 16'h0001; // R10
                  if (wrap)
                     phase_q <= PH_WARN; // R4
               end
               PH_WARN: begin
                  warnCnt_q <= warnCnt_q + 8'h01;
               end
               default: phase_q <= PH_RUN;
            endcase
         end
         // Event set wins over write-one clear
         stat_q[0] <= evPre | (stat_q[0] & ~(wrStatus & wData_q[0])); // R4
         stat_q[1] <= evRst | (stat_q[1] & ~(wrStatus & wData_q[1])); // R4
         if (evRst)
            rstHold_q <= `SWD_RST_HOLD;
         else if (rstHold_q != 5'h00)
            rstHold_q <= rstHold_q - 5'h01;
         resetReq_q <= evRst || rstHold_q > 5'h01; // R4
         irq_q <= |((stat_q | {evRst, evPre}) & mask_q);
      end
   end

   // ---------------------------------------------
   // Read channel
   // ---------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `SWD_CTRL_OFS: s_axi_rdata <= {29'h0, fast_q, 1'b0, run_q};
               `SWD_RELOAD_OFS: s_axi_rdata <= {16'h0000, reload_q};
               `SWD_SERVICE_OFS: s_axi_rdata <= 32'h00000000;
               `SWD_COUNT_OFS: s_axi_rdata <= {16'h0000, count_q};
               `SWD_STATUS_OFS: s_axi_rdata <= {29'h0, run_q, stat_q};
               `SWD_IRQ_MASK_OFS: s_axi_rdata <= {30'h0, mask_q};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* swd_watchdog_props.sv */
// Purpose: Port-level timing checks for the watchdog.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Bound to every watchdog instance.
`timescale 1ns/1ps
`default_nettype none
module swd_watchdog_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus handshakes
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // System
   input wire logic irq_q,
   input wire logic resetReq_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_reset_quiet: assert property ($past(rst) |-> !irq_q && !resetReq_q)
      else $error("outputs active after reset");
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held");
   a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready held");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read data");
   a_write_answer: assert property (s_axi_awready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   a_req_width: assert property ($rose(resetReq_q) |=> resetReq_q[*8])
      else $error("reset request too short");
   a_req_release: assert property ($rose(resetReq_q) |-> ##16 !resetReq_q)
      else $error("reset request too long");
   a_req_rare: assert property ($fell(resetReq_q) |=> !resetReq_q[*8])
      else $error("reset request repeats");
endmodule
bind swd_watchdog swd_watchdog_props uProps (.clk, .rst, .s_axi_awready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .irq_q, .resetReq_q);
`default_nettype wire

/* tb_supervisory_watchdog_timer.sv */
// Purpose: Self-checking bench for the watchdog.
// Assumes: Fast divider and high reload keep overflow runs short.
// Notes: Register rows first, then reset, timing and overflow cases.
`include "swd_regs.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin badCount++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_supervisory_watchdog_timer;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r; logic [31:0] q;} swd_row_t;
   localparam int PW = 2;
   logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, irq_q, resetReq_q;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, keep;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int badCount = 0, nCompared = 0, n;
   // Unmapped and unaligned places must refuse
   swd_row_t rows [5] = '{'{`SWD_RELOAD_OFS, 32'h5a5a1234, 2'h0, 32'h00001234},
      '{`SWD_IRQ_MASK_OFS, 32'h00000003, 2'h0, 32'h00000003},
      '{`SWD_IRQ_MASK_OFS, 32'h00000000, 2'h0, 32'h00000000},
      '{8'h18, 32'h00000001, 2'h2, 32'h0}, '{8'h02, 32'h00000001, 2'h2, 32'h0}};
   swd_watchdog #(.PREWARN_TICKS(PW)) dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_q, .resetReq_q);
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic endSim;
      $display("compared=%0d mismatches=%0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic hang;
      badCount++;
      endSim();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && k < 40);
      if (s_axi_bvalid !== 1'b1) hang();
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      int k;
      k = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && k < 40);
      if (s_axi_rvalid !== 1'b1) hang();
      resp = s_axi_rresp;
      rd = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   // Counts edges until the chosen output is high
   task automatic waitHigh(input bit req, input int lim);
      n = 0;
      while ((req ? resetReq_q : irq_q) !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n >= lim) hang();
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         `CHK(resp, rows[i].r)
         rdr(rows[i].a);
         `CHK(resp, rows[i].r)
         if (rows[i].r == 2'h0) `CHK(rd, rows[i].q)
      end
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rdr(`SWD_STATUS_OFS);
      `CHK(rd, 32'h00000004)
      rdr(`SWD_RELOAD_OFS);
      `CHK(rd, 32'h0000fffc)
      wr(`SWD_CTRL_OFS, 32'h00000001);
      repeat (`SWD_DIV_SLOW + 100) @(posedge clk);
      rdr(`SWD_COUNT_OFS);
      `CHK(rd, 32'h0000fffd)
      wr(`SWD_RELOAD_OFS, 32'h0000fff0);
      wr(`SWD_CTRL_OFS, 32'h00000005);
      rdr(`SWD_COUNT_OFS);
      `CHK(rd, 32'h0000fff0)
      repeat (3 * `SWD_DIV_FAST + 100) @(posedge clk);
      rdr(`SWD_COUNT_OFS);
      `CHK(rd, 32'h0000fff3)
      // Old prescaler phase would tick inside this wait
      wr(`SWD_SERVICE_OFS, `SWD_SVC_KEY);
      repeat (200) @(posedge clk);
      rdr(`SWD_COUNT_OFS);
      `CHK(rd, 32'h0000fff0)
      wr(`SWD_CTRL_OFS, 32'h00000006);
      rdr(`SWD_COUNT_OFS);
      keep = rd;
      repeat (600) @(posedge clk);
      rdr(`SWD_STATUS_OFS);
      `CHK(rd, 32'h00000000)
      rdr(`SWD_COUNT_OFS);
      `CHK(rd, keep)
      wr(`SWD_CTRL_OFS, 32'h00000005);
      repeat (16 * `SWD_DIV_FAST + 64) @(posedge clk);
      rdr(`SWD_STATUS_OFS);
      `CHK(rd, 32'h00000005)
      `CHK(irq_q, 1'b0)
      wr(`SWD_IRQ_MASK_OFS, 32'h00000003);
      waitHigh(1'b0, 4);
      waitHigh(1'b1, PW * `SWD_DIV_FAST);
      `CHK(n > 64, 1'b1)
      rdr(`SWD_STATUS_OFS);
      `CHK(rd, 32'h00000007)
      wr(`SWD_STATUS_OFS, 32'h00000003);
      rdr(`SWD_STATUS_OFS);
      `CHK(rd, 32'h00000004)
      `CHK(irq_q, 1'b0)
      endSim();
   end
endmodule
`default_nettype wire
